/* File: frs_pkg.sv */
`default_nettype none
// ----------------------------------------------------------------
// shared constants
// ----------------------------------------------------------------
package frs_pkg;
    localparam int FW = 24;
    localparam int PW = 16;
    localparam int AW = 12;

    // register byte offsets
    localparam logic [AW-1:0] OFS_MAIN_SRC  = 12'h000;
    localparam logic [AW-1:0] OFS_AUX_SRC   = 12'h004;
    localparam logic [AW-1:0] OFS_AUX_BASE  = 12'h008;
    localparam logic [AW-1:0] OFS_AUX_PCT   = 12'h00C;
    localparam logic [AW-1:0] OFS_MODE      = 12'h010;
    localparam logic [AW-1:0] OFS_MAX_FREQ  = 12'h014;
    localparam logic [AW-1:0] OFS_PRESET    = 12'h018;
    localparam logic [AW-1:0] OFS_OFFSET    = 12'h01C;
    localparam logic [AW-1:0] OFS_TARGET    = 12'h020;
    localparam logic [AW-1:0] OFS_PULSE     = 12'h024;
    localparam logic [AW-1:0] OFS_STATUS    = 12'h028;
    localparam logic [AW-1:0] OFS_STEP_BASE = 12'h040;
    localparam logic [AW-1:0] OFS_STEP_END  = 12'h07C;

    // values after reset, frequency in 0.01 Hz, percent in 0.01 %
    localparam logic [15:0] RST_ZERO     = 16'h0000;
    localparam logic [15:0] RST_MAX_FREQ = 16'h1388;
    localparam logic [15:0] RST_PRESET   = 16'h1388;

    localparam logic [15:0] PCT_FULL    = 16'h2710;
    localparam logic [15:0] AUX_PCT_MAX = 16'h0096;
    localparam logic [15:0] PCT_UNIT    = 16'h0064;
    localparam logic [15:0] DEC_RADIX   = 16'h000A;
    localparam logic [15:0] DIG_STEP    = 16'h0001;

    // pulse channel timing
    localparam int PULSE_MAX_HZ   = 100000;
    localparam int GATE_US        = 10000;
    localparam int CLK_MHZ        = 100;
    localparam int GATE_CYC       = GATE_US * CLK_MHZ;
    localparam int PULSE_FULL_CNT = PULSE_MAX_HZ / 1000 * GATE_US / 1000;

    typedef enum logic [3:0] {
        SRC_DIG_VOL, SRC_DIG_RET, SRC_AN_A, SRC_AN_VC, SRC_AN_BI,
        SRC_PULSE, SRC_STEP, SRC_SEQ, SRC_REG, SRC_COMM
    } frs_src_t;

    typedef enum logic [2:0] {
        MODE_MAIN, MODE_COMB, MODE_SW_MA, MODE_SW_MC, MODE_SW_AC
    } frs_mode_t;

    typedef enum logic [1:0] {OP_SUM, OP_DIFF, OP_MAX, OP_MIN} frs_op_t;
endpackage
`default_nettype wire

/* File: frs_terminal_model.sv */
`timescale 1ns/1ps
`default_nettype none
module frs_terminal_model #(
    parameter int HALF = 2
) (
    input  wire logic clk,
    input  wire logic run,
    input  wire logic fast,
    output var logic  pulse = 1'b0
);
    int cnt = 0;
    // ----------------------------------------------------------------
    // pulse train on the dedicated terminal, low when idle
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!run) begin
            cnt   <= 0;
            pulse <= 1'b0;
        end else if (fast || cnt == HALF - 1) begin
            cnt   <= 0;
            pulse <= ~pulse;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

/* File: frs_top.sv */
`timescale 1ns/1ps
`default_nettype none
module frs_top
    import frs_pkg::*;
#(
    parameter int GATE_CYCLES = frs_pkg::GATE_CYC
) (
    // clock and reset
    input  wire logic                    SYS_CLK,
    input  wire logic                    RST_N,
    // apb slave
    input  wire logic                    PSEL,
    input  wire logic                    PENABLE,
    input  wire logic                    PWRITE,
    input  wire logic [frs_pkg::AW-1:0]  PADDR,
    input  wire logic [31:0]             PWDATA,
    output logic      [31:0]             PRDATA,
    output logic                         PREADY,
    output logic                         PSLVERR,
    // terminals
    input  wire logic                    PULSE_INPUT_TERMINAL,
    input  wire logic [3:0]              DIGITAL_INPUT_TERMINAL,
    input  wire logic                    FREQ_SWITCH,
    input  wire logic                    UP_CMD,
    input  wire logic                    DOWN_CMD,
    // percent sources, signed 0.01 %
    input  wire logic [frs_pkg::PW-1:0]  ANALOG_VOLTAGE_IN_A,
    input  wire logic [frs_pkg::PW-1:0]  ANALOG_VOLTAGE_CURRENT_IN,
    input  wire logic [frs_pkg::PW-1:0]  ANALOG_BIPOLAR_IN,
    input  wire logic [frs_pkg::PW-1:0]  STEP_SEQUENCER_SOURCE,
    input  wire logic [frs_pkg::PW-1:0]  PROCESS_REGULATOR_SOURCE,
    input  wire logic [frs_pkg::PW-1:0]  COMM_SOURCE,
    // result, signed 0.01 Hz
    output logic      [frs_pkg::FW-1:0]  TARGET_FREQ
);
    import frs_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic signed [FW-1:0] pct_scale(
        input logic signed [PW-1:0] p,
        input logic signed [FW-1:0] base
    );
        logic signed [FW+PW-1:0] prod;
        prod = FW'(p) * base;
        pct_scale = FW'(prod / $signed({1'b0, PCT_FULL}));
    endfunction

    function automatic logic signed [FW-1:0] mag(input logic signed [FW-1:0] v);
        mag = v[FW-1] ? -v : v;
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [15:0]           main_src_r;
    logic [15:0]           aux_src_r;
    logic [15:0]           aux_base_r;
    logic [15:0]           aux_pct_r;
    logic [15:0]           mode_r;
    logic [15:0]           max_freq_r;
    logic [15:0]           preset_r;
    logic [15:0]           offset_r;
    logic [PW-1:0]         steps_r [16];
    logic [15:0]           main_dig_r;
    logic [15:0]           aux_dig_r;
    logic                  pin_d_r;
    logic [31:0]           gate_r;
    logic [15:0]           edge_cnt_r;
    logic [PW-1:0]         pulse_pct_r;
    logic [FW-1:0]         target_r;
    logic [31:0]           prdata_r;
    logic                  pready_r;
    logic                  pslverr_r;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire        acc      = PSEL & PENABLE;
    wire        done     = acc & pready_r;
    wire        wr_en    = done & PWRITE;
    wire        in_steps = (PADDR >= OFS_STEP_BASE) && (PADDR <= OFS_STEP_END) && (PADDR[1:0] == 2'b00);
    wire [3:0]  step_idx = PADDR[5:2];
    wire [15:0] wdat     = PWDATA[15:0];
    wire [15:0] aux_pct_w = (wdat > AUX_PCT_MAX) ? AUX_PCT_MAX : wdat;
    wire        wr_preset = wr_en && (PADDR == OFS_PRESET);
    wire        conflict  = (main_src_r == aux_src_r);

    logic [31:0] rd_data;
    logic        rd_hit;
    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h0000_0000;
        unique case (PADDR)
            OFS_MAIN_SRC: rd_data = {16'h0000, main_src_r};
            OFS_AUX_SRC:  rd_data = {16'h0000, aux_src_r};
            OFS_AUX_BASE: rd_data = {16'h0000, aux_base_r};
            OFS_AUX_PCT:  rd_data = {16'h0000, aux_pct_r};
            OFS_MODE:     rd_data = {16'h0000, mode_r};
            OFS_MAX_FREQ: rd_data = {16'h0000, max_freq_r};
            OFS_PRESET:   rd_data = {16'h0000, preset_r};
            OFS_OFFSET:   rd_data = {16'h0000, offset_r};
            OFS_TARGET:   rd_data = 32'(signed'(target_r));
            OFS_PULSE:    rd_data = {16'h0000, pulse_pct_r};
            OFS_STATUS:   rd_data = {24'h00_0000, DIGITAL_INPUT_TERMINAL, 2'b00, FREQ_SWITCH, conflict};
            default: begin
                if (in_steps) begin
                    rd_data = {16'h0000, steps_r[step_idx]};
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= acc & ~pready_r;
            prdata_r  <= (acc & ~pready_r & ~PWRITE) ? rd_data : prdata_r;
            pslverr_r <= acc & ~pready_r & ~rd_hit;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            main_src_r <= RST_ZERO;
            aux_src_r  <= RST_ZERO;
            aux_base_r <= RST_ZERO;
            aux_pct_r  <= RST_ZERO;
            mode_r     <= RST_ZERO;
            max_freq_r <= RST_MAX_FREQ;
            preset_r   <= RST_PRESET;
            offset_r   <= RST_ZERO;
        end else if (wr_en) begin
            if (PADDR == OFS_MAIN_SRC) main_src_r <= wdat;
            if (PADDR == OFS_AUX_SRC)  aux_src_r  <= wdat;
            if (PADDR == OFS_AUX_BASE) aux_base_r <= wdat;
            if (PADDR == OFS_AUX_PCT)  aux_pct_r  <= aux_pct_w;
            if (PADDR == OFS_MODE)     mode_r     <= wdat;
            if (PADDR == OFS_MAX_FREQ) max_freq_r <= wdat;
            if (PADDR == OFS_PRESET)   preset_r   <= wdat;
            if (PADDR == OFS_OFFSET)   offset_r   <= wdat;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < 16; i++) begin
                steps_r[i] <= RST_ZERO;
            end
        end else if (wr_en && in_steps) begin
            steps_r[step_idx] <= wdat;
        end
    end

    // ----------------------------------------------------------------
    // digital setting, up/down
    // ----------------------------------------------------------------
    wire        main_is_dig = (main_src_r < 16'h0002);
    wire        aux_is_dig  = (aux_src_r < 16'h0002);
    wire        up_only     = UP_CMD & ~DOWN_CMD;
    wire        dn_only     = DOWN_CMD & ~UP_CMD;
    wire [15:0] main_dig_nxt = (up_only && main_dig_r < max_freq_r) ? main_dig_r + DIG_STEP :
                               (dn_only && main_dig_r != 16'h0000) ? main_dig_r - DIG_STEP : main_dig_r;
    wire [15:0] aux_dig_nxt  = (up_only && aux_dig_r < max_freq_r) ? aux_dig_r + DIG_STEP :
                               (dn_only && aux_dig_r != 16'h0000) ? aux_dig_r - DIG_STEP : aux_dig_r;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            main_dig_r <= RST_PRESET;
            aux_dig_r  <= RST_ZERO;
        end else begin
            main_dig_r <= wr_preset ? wdat : (main_is_dig ? main_dig_nxt : main_dig_r);
            aux_dig_r  <= aux_is_dig ? aux_dig_nxt : aux_dig_r;
        end
    end

    // ----------------------------------------------------------------
    // pulse channel
    // ----------------------------------------------------------------
    wire        pin_rise  = PULSE_INPUT_TERMINAL & ~pin_d_r;
    wire        gate_end  = (gate_r == 32'(GATE_CYCLES - 1));
    wire        cnt_full  = (edge_cnt_r >= 16'(PULSE_FULL_CNT));
    wire [31:0] pulse_lin = 32'(edge_cnt_r) * 32'(PCT_FULL) / 32'(PULSE_FULL_CNT);

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_d_r     <= 1'b0;
            gate_r      <= 32'h0000_0000;
            edge_cnt_r  <= RST_ZERO;
            pulse_pct_r <= RST_ZERO;
        end else begin
            pin_d_r    <= PULSE_INPUT_TERMINAL;
            gate_r     <= gate_end ? 32'h0000_0000 : gate_r + 32'h0000_0001;
            edge_cnt_r <= gate_end ? 16'(pin_rise) : ((pin_rise && !cnt_full) ? edge_cnt_r + 16'h0001 : edge_cnt_r);
            if (gate_end) begin
                pulse_pct_r <= cnt_full ? PCT_FULL : pulse_lin[PW-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // source channels
    // ----------------------------------------------------------------
    wire signed [FW-1:0] max_f    = FW'(max_freq_r);
    wire signed [FW-1:0] main_dig = FW'(main_dig_r);
    wire signed [FW-1:0] aux_dig  = FW'(aux_dig_r);

    logic [PW-1:0] chan_pct [10];
    assign chan_pct[SRC_DIG_VOL] = RST_ZERO;
    assign chan_pct[SRC_DIG_RET] = RST_ZERO;
    assign chan_pct[SRC_AN_A]    = ANALOG_VOLTAGE_IN_A;
    assign chan_pct[SRC_AN_VC]   = ANALOG_VOLTAGE_CURRENT_IN;
    assign chan_pct[SRC_AN_BI]   = ANALOG_BIPOLAR_IN;
    assign chan_pct[SRC_PULSE]   = pulse_pct_r;
    assign chan_pct[SRC_STEP]    = steps_r[DIGITAL_INPUT_TERMINAL];
    assign chan_pct[SRC_SEQ]     = STEP_SEQUENCER_SOURCE;
    assign chan_pct[SRC_REG]     = PROCESS_REGULATOR_SOURCE;
    assign chan_pct[SRC_COMM]    = COMM_SOURCE;

    wire main_ok = (main_src_r <= 16'(SRC_COMM));
    wire aux_ok  = (aux_src_r <= 16'(SRC_COMM));
    wire [3:0] main_code = main_src_r[3:0];
    wire [3:0] aux_code  = aux_src_r[3:0];
    wire aux_spanned = aux_ok && (aux_code >= 4'(SRC_AN_A)) && (aux_code <= 4'(SRC_PULSE));

    // standard scaling against max; main digital uses the preset-based set value
    wire signed [FW-1:0] main_val = !main_ok ? '0 :
                                    main_is_dig ? main_dig : pct_scale(chan_pct[main_code], max_f);
    wire signed [FW-1:0] aux_ind  = !aux_ok ? '0 :
                                    aux_is_dig ? main_dig : pct_scale(chan_pct[aux_code], max_f);

    // auxiliary span for combination
    wire signed [FW-1:0] span_base = (aux_base_r == 16'h0000) ? max_f : main_val;
    wire signed [FW+PW-1:0] span_prod = span_base * $signed({1'b0, aux_pct_r});
    wire signed [FW-1:0] span = FW'(span_prod / $signed({1'b0, PCT_UNIT}));
    wire signed [FW-1:0] aux_comb = !aux_ok ? '0 :
                                    aux_is_dig ? aux_dig :
                                    aux_spanned ? pct_scale(chan_pct[aux_code], span) : aux_ind;

    // ----------------------------------------------------------------
    // combination and selection
    // ----------------------------------------------------------------
    wire [15:0] unit_w = mode_r % DEC_RADIX;
    wire [15:0] tens_w = (mode_r / DEC_RADIX) % DEC_RADIX;
    wire [1:0]  op_sel = tens_w[1:0];
    wire        mag_ge = mag(main_val) >= mag(aux_comb);

    logic signed [FW-1:0] comb_raw;
    always_comb begin
        comb_raw = main_val;
        unique case (frs_op_t'(op_sel))
            OP_SUM:  comb_raw = main_val + aux_comb;
            OP_DIFF: comb_raw = main_val - aux_comb;
            OP_MAX:  comb_raw = mag_ge ? main_val : aux_comb;
            OP_MIN:  comb_raw = mag_ge ? aux_comb : main_val;
        endcase
    end

    wire signed [FW-1:0] comb_res = comb_raw + FW'(signed'(offset_r));

    logic signed [FW-1:0] target_nxt;
    always_comb begin
        target_nxt = main_val;
        if (unit_w <= 16'(MODE_SW_AC)) begin
            unique case (frs_mode_t'(unit_w[2:0]))
                MODE_MAIN:  target_nxt = main_val;
                MODE_COMB:  target_nxt = comb_res;
                MODE_SW_MA: target_nxt = FREQ_SWITCH ? aux_ind : main_val;
                MODE_SW_MC: target_nxt = FREQ_SWITCH ? comb_res : main_val;
                MODE_SW_AC: target_nxt = FREQ_SWITCH ? comb_res : aux_ind;
                default:    target_nxt = main_val;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            target_r <= '0;
        end else begin
            target_r <= target_nxt;
        end
    end

    assign TARGET_FREQ = target_r;
    assign PRDATA      = prdata_r;
    assign PREADY      = pready_r;
    assign PSLVERR     = pslverr_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_gate_full;
        gate_end && cnt_full;
    endsequence

    property p_pulse_bound;
        pulse_pct_r <= PCT_FULL;
    endproperty
    a_pulse_bound: assert property (p_pulse_bound) else $error("pulse percent above full scale");

    property p_pulse_full;
        s_gate_full |=> (pulse_pct_r == PCT_FULL);
    endproperty
    a_pulse_full: assert property (p_pulse_full) else $error("full pulse rate not at full scale");

    property p_step_pick;
        (main_src_r == 16'(SRC_STEP)) && (unit_w == 16'h0000) |=>
            target_r == pct_scale($past(steps_r[DIGITAL_INPUT_TERMINAL]), $past(max_f));
    endproperty
    a_step_pick: assert property (p_step_pick) else $error("step reference not scaled by max");

    property p_aux_dig;
        aux_is_dig && up_only && (aux_dig_r < max_freq_r) && !wr_preset |=>
            aux_dig_r == $past(aux_dig_r) + DIG_STEP;
    endproperty
    a_aux_dig: assert property (p_aux_dig) else $error("aux digital did not step up");

    property p_aux_pct;
        wr_en && (PADDR == OFS_AUX_PCT) && (wdat > AUX_PCT_MAX) |=> aux_pct_r == AUX_PCT_MAX;
    endproperty
    a_aux_pct: assert property (p_aux_pct) else $error("aux range not limited");

    property p_main_only;
        (unit_w == 16'(MODE_MAIN)) |=> target_r == $past(main_val);
    endproperty
    a_main_only: assert property (p_main_only) else $error("mode 0 target not main");

    property p_sw_aux;
        (unit_w == 16'(MODE_SW_AC)) && !FREQ_SWITCH |=> target_r == $past(aux_ind);
    endproperty
    a_sw_aux: assert property (p_sw_aux) else $error("mode 4 idle not aux");

    property p_comb_sum;
        (unit_w == 16'(MODE_COMB)) && (op_sel == 2'(OP_SUM)) |=>
            target_r == $past(main_val) + $past(aux_comb) + FW'(signed'($past(offset_r)));
    endproperty
    a_comb_sum: assert property (p_comb_sum) else $error("sum with offset wrong");

    property p_comb_max;
        (op_sel == 2'(OP_MAX)) |-> mag(comb_raw) >= mag(main_val) && mag(comb_raw) >= mag(aux_comb);
    endproperty
    a_comb_max: assert property (p_comb_max) else $error("max magnitude wrong");

    property p_apb_ans;
        acc && !pready_r |=> pready_r ##1 !pready_r;
    endproperty
    a_apb_ans: assert property (p_apb_ans) else $error("apb answer timing wrong");
endmodule
`default_nettype wire

/* File: tb_frs_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_frs_top;
    import frs_pkg::*;
    localparam int GC = 2000;
    logic SYS_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, FREQ_SWITCH = 0, UP_CMD = 0, DOWN_CMD = 0;
    logic run = 0, fast = 0, PULSE_INPUT_TERMINAL, PREADY, PSLVERR;
    logic [AW-1:0] PADDR = '0;
    logic [31:0]   PWDATA = '0, PRDATA, q;
    logic [3:0]    DIGITAL_INPUT_TERMINAL = 4'hF;
    logic [PW-1:0] an_a = 16'h0FA0, an_vc = 16'h07D0, an_bi = 16'hF830, seq = 16'h0BB8, reg_s = 16'h0FA0, comm = 16'h1770;
    logic [FW-1:0] TARGET_FREQ;
    int failures = 0, checked = 0;
    int tbl[10] = '{5000, 5000, 2000, 1000, -1000, 2500, 2500, 1500, 2000, 3000};
    frs_top #(.GATE_CYCLES(GC)) frs_top_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .PULSE_INPUT_TERMINAL(PULSE_INPUT_TERMINAL), .DIGITAL_INPUT_TERMINAL(DIGITAL_INPUT_TERMINAL),
        .FREQ_SWITCH(FREQ_SWITCH), .UP_CMD(UP_CMD), .DOWN_CMD(DOWN_CMD), .ANALOG_VOLTAGE_IN_A(an_a),
        .ANALOG_VOLTAGE_CURRENT_IN(an_vc), .ANALOG_BIPOLAR_IN(an_bi), .STEP_SEQUENCER_SOURCE(seq),
        .PROCESS_REGULATOR_SOURCE(reg_s), .COMM_SOURCE(comm), .TARGET_FREQ(TARGET_FREQ));
    frs_terminal_model #(.HALF(2)) frs_terminal_model_inst (.clk(SYS_CLK), .run(run), .fast(fast),
        .pulse(PULSE_INPUT_TERMINAL));
    always #5 SYS_CLK = ~SYS_CLK;
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d, input logic [31:0] err);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge SYS_CLK);
        end while (PREADY !== 1'b1);
        q = PRDATA;
        chk({31'h0, PSLVERR}, err);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0000_0000);
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [31:0] e, input logic [31:0] err);
        apb(1'b0, a, 32'h0, err);
        chk(q, e);
    endtask
    task automatic cfg(input int m, input int x, input int md);
        wr(OFS_MAIN_SRC, m);
        wr(OFS_AUX_SRC, x);
        wr(OFS_MODE, md);
        repeat (3) @(posedge SYS_CLK);
    endtask
    task automatic tgt(input int e);
        chk({{8{TARGET_FREQ[FW-1]}}, TARGET_FREQ}, e);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        tgt(0);
        @(posedge SYS_CLK);
        RST_N <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        tgt(5000);
        rd(OFS_AUX_SRC, 0, 0);
        rd(OFS_AUX_BASE, 0, 0);
        rd(OFS_AUX_PCT, 0, 0);
        rd(OFS_MODE, 0, 0);
        rd(OFS_MAX_FREQ, 5000, 0);
        rd(12'h030, 0, 1);
        wr(OFS_AUX_PCT, 200);
        rd(OFS_AUX_PCT, 150, 0);
        wr(OFS_AUX_PCT, 100);
        $display("test reset done");
    endtask
    task automatic t_sources();
        wr(OFS_STEP_END, 32'h0000_1388);
        wr(OFS_STEP_BASE + 12'h00C, 32'h0000_0FA0);
        run <= 1'b1;
        fast <= 1'b1;
        repeat (2 * GC + 10) @(posedge SYS_CLK);
        rd(OFS_PULSE, 32'h0000_2710, 0);
        fast <= 1'b0;
        repeat (2 * GC + 10) @(posedge SYS_CLK);
        rd(OFS_PULSE, 32'h0000_1388, 0);
        for (int c = 0; c < 10; c++) begin
            cfg(c, c == 9 ? 0 : 9, 0);
            tgt(tbl[c]);
        end
        for (int c = 0; c < 9; c++) begin
            cfg(9, c, 4);
            tgt(tbl[c]);
        end
        DIGITAL_INPUT_TERMINAL <= 4'h3;
        cfg(6, 9, 0);
        tgt(2000);
        $display("test sources done");
    endtask
    task automatic t_comb();
        int ex[4] = '{3000, 1000, 2000, 1000};
        for (int t = 0; t < 4; t++) begin
            cfg(2, 3, t * 10 + 1);
            tgt(ex[t]);
        end
        wr(OFS_OFFSET, 100);
        cfg(2, 3, 1);
        tgt(3100);
        wr(OFS_AUX_BASE, 1);
        wr(OFS_AUX_PCT, 150);
        repeat (3) @(posedge SYS_CLK);
        tgt(2700);
        wr(OFS_AUX_BASE, 0);
        wr(OFS_AUX_PCT, 100);
        an_a <= 16'hE890;
        cfg(2, 3, 21);
        tgt(-2900);
        rd(OFS_TARGET, 32'hFFFF_F4AC, 0);
        cfg(2, 3, 31);
        tgt(1100);
        an_a <= 16'h0FA0;
        rd(OFS_STATUS, 32'h0000_0030, 0);
        $display("test comb done");
    endtask
    task automatic t_switch();
        int md[7] = '{2, 2, 3, 3, 4, 4, 5};
        int ex[7] = '{2000, 1000, 2000, 3100, 1000, 3100, 2000};
        for (int i = 0; i < 7; i++) begin
            cfg(2, 3, md[i]);
            FREQ_SWITCH <= i[0];
            repeat (2) @(posedge SYS_CLK);
            tgt(ex[i]);
        end
        FREQ_SWITCH <= 1'b0;
        $display("test switch done");
    endtask
    task automatic t_updown();
        wr(OFS_OFFSET, 0);
        wr(OFS_PRESET, 7000);
        cfg(2, 0, 1);
        tgt(2000);
        UP_CMD <= 1'b1;
        repeat (5) @(posedge SYS_CLK);
        UP_CMD <= 1'b0;
        DOWN_CMD <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        DOWN_CMD <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        tgt(2003);
        $display("test updown done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge SYS_CLK);
        t_reset();
        t_sources();
        t_comb();
        t_switch();
        t_updown();
        summarize();
    end
    initial begin
        #500000;
        failures++;
        summarize();
    end
endmodule
`default_nettype wire
